// ### rtl/sadc_pkg.sv
// Package for the 10-bit successive-approximation converter control block.
// Assumes one 50 MHz clock and byte-wide register access from the core.
package sadc_pkg;
  // Register byte addresses
  localparam logic [15:0] RESULT_LO_ADDR  = 16'hff14;
  localparam logic [15:0] RESULT_HI_ADDR  = 16'hff15;
  localparam logic [15:0] MODE_ADDR       = 16'hff80;
  localparam logic [15:0] CHANNEL_ADDR    = 16'hff84;
  // Reset values
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  CHANNEL_RESET   = 8'h00;
  // Field positions
  localparam int          ENABLE_BIT      = 7;
  localparam int          TIME_SEL_LSB    = 3;
  localparam int          RESULT_LSB      = 6;
  localparam int          SAR_BITS        = 10;
  // Conversion-time codes and their lengths in clock cycles
  localparam logic [2:0]  TIME_CODE_144   = 3'h0;
  localparam logic [2:0]  TIME_CODE_120   = 3'h1;
  localparam logic [2:0]  TIME_CODE_96    = 3'h2;
  localparam logic [2:0]  TIME_CODE_72    = 3'h4;
  localparam logic [7:0]  CYCLES_144      = 8'h90;
  localparam logic [7:0]  CYCLES_120      = 8'h78;
  localparam logic [7:0]  CYCLES_96       = 8'h60;
  localparam logic [7:0]  CYCLES_72       = 8'h48;
  // Highest legal channel code
  localparam logic [2:0]  CHANNEL_MAX     = 3'h5;
  // Sequencer states
  typedef enum logic [2:0] {
    SADC_IDLE   = 3'b001,
    SADC_SAMPLE = 3'b010,
    SADC_DECIDE = 3'b100
  } sadc_state_t;
endpackage

// ### rtl/sadc_step_timer.sv
// Step timer: one-cycle enable at the end of each phase of a conversion.
// Assumes the caller presents the next phase length when the count reaches zero; it reloads itself.
`timescale 1ns/10ps
module sadc_step_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] length,
  output logic                  tick
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // Counts down from length-1; restart wins over the running count
  always_comb begin
    if (restart || count_q == '0) begin
      count_d = length - WIDTH'(1);
    end else begin
      count_d = count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign tick = !restart && (count_q == '0);
endmodule

// ### rtl/sadc_control.sv
// Converter control: mode, channel and result registers plus the sequencer.
// Assumes a byte bus from the core and a comparator that settles in one step.
//
// Summary of operation
// - Result register is sixteen bits; its six low bits always read zero.
// - End of conversion copies the approximation left-justified into the result.
// - Reset clears the result register to zero.
// - Mode register resets to zero; bit 7 enables conversion.
// - Mode bits 5 to 3 choose 144, 120, 96 or 72 cycles.
// - First result after enabling may be invalid and is discarded.
// - Channel register resets to zero; low three bits pick inputs zero to five.
// - Sample the input first, then hold until the conversion ends.
// - Start with bit 9 set at the half tap; keep it if input not below.
// - Each lower bit is tried, tap from decided bits, kept if input not below.
// - After bit 0, latch the result and raise the end request together.
// - Convert back to back while enabled; a mode or channel write restarts the conversion.
// - A result read at end of conversion wins; the new result lands after.
// - A mode or channel write at end of conversion drops the result and request.
`timescale 1ns/10ps
module sadc_control #(
  parameter int STEP_CYCLES_MAX = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        comparator_above,
  output logic      [9:0]  tap_select,
  output logic      [2:0]  channel_select,
  output logic             sample_enable,
  output logic             conversion_end_irq
);
  sadc_pkg::sadc_state_t state_q, state_d;
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  chan_q, chan_d;
  logic [9:0]  sar_q, sar_d;
  logic [9:0]  trial_q, trial_d;
  logic [15:0] result_q, result_d;
  logic [9:0]  pend_q, pend_d;
  logic        pend_valid_q, pend_valid_d;
  logic        irq_q, irq_d;
  logic        ctrl_write, result_read, done, restart, tick;
  logic [7:0]  total_cycles, step_len, sample_len;

  // Decode of the conversion-time code into cycles
  function automatic logic [7:0] time_cycles(input logic [2:0] code);
    unique case (code)
      sadc_pkg::TIME_CODE_120: time_cycles = sadc_pkg::CYCLES_120;
      sadc_pkg::TIME_CODE_96:  time_cycles = sadc_pkg::CYCLES_96;
      sadc_pkg::TIME_CODE_72:  time_cycles = sadc_pkg::CYCLES_72;
      default:                 time_cycles = sadc_pkg::CYCLES_144;
    endcase
  endfunction

  // Prohibited codes fall back to the longest time, the safe side of 14 us
  assign total_cycles = time_cycles(mode_q[sadc_pkg::TIME_SEL_LSB +: 3]);
  // Eleven equal shares: sampling takes one share plus the remainder, each bit one share.
  // Summing back to the selected count keeps the period exact for every legal code.
  assign step_len     = total_cycles / 8'(sadc_pkg::SAR_BITS + 1);
  assign sample_len   = total_cycles - 8'(step_len * 8'(sadc_pkg::SAR_BITS));

  assign ctrl_write  = bus_write &&
                       (bus_addr == sadc_pkg::MODE_ADDR || bus_addr == sadc_pkg::CHANNEL_ADDR);
  assign result_read = bus_read &&
                       (bus_addr == sadc_pkg::RESULT_LO_ADDR || bus_addr == sadc_pkg::RESULT_HI_ADDR);
  assign done        = (state_q == sadc_pkg::SADC_DECIDE) && tick && trial_q[0];
  // Tick stays out of restart: tick depends on restart, and the timer reloads itself at zero
  assign restart     = ctrl_write || state_q == sadc_pkg::SADC_IDLE;

  sadc_step_timer #(
    .WIDTH (8)
  ) u_timer (
    .clk     (clk),
    .reset   (reset),
    .restart (restart),
    .length  ((state_d == sadc_pkg::SADC_SAMPLE) ? sample_len : step_len),
    .tick    (tick)
  );

  // Registers, sequencer and result path
  always_comb begin
    mode_d       = mode_q;
    chan_d       = chan_q;
    state_d      = state_q;
    sar_d        = sar_q;
    trial_d      = trial_q;
    result_d     = result_q;
    pend_d       = pend_q;
    pend_valid_d = pend_valid_q;
    irq_d        = 1'b0;
    // A pending result lands once no read competes
    if (pend_valid_q && !result_read) begin
      result_d     = {pend_q, 6'h00};
      pend_valid_d = 1'b0;
    end
    if (bus_write && bus_addr == sadc_pkg::MODE_ADDR) begin
      mode_d = bus_wdata;
    end
    if (bus_write && bus_addr == sadc_pkg::CHANNEL_ADDR) begin
      chan_d = bus_wdata;
    end
    if (ctrl_write) begin
      // Writes abort and restart; they win over end of conversion
      state_d = mode_d[sadc_pkg::ENABLE_BIT] ? sadc_pkg::SADC_SAMPLE
                                             : sadc_pkg::SADC_IDLE;
      sar_d   = '0;
      trial_d = '0;
    end else begin
      unique case (state_q)
        sadc_pkg::SADC_IDLE: begin
          if (mode_q[sadc_pkg::ENABLE_BIT]) begin
            // First conversion gets a full sample phase; software still drops it
            state_d = sadc_pkg::SADC_SAMPLE;
          end
        end
        sadc_pkg::SADC_SAMPLE: begin
          if (tick) begin
            state_d = sadc_pkg::SADC_DECIDE;
            sar_d   = 10'h200;
            trial_d = 10'h200;
          end
        end
        sadc_pkg::SADC_DECIDE: begin
          if (tick) begin
            // Keep or drop the trial bit, then try the next one
            sar_d = comparator_above ? sar_q : (sar_q & ~trial_q);
            if (trial_q[0]) begin
              if (result_read) begin
                pend_d       = sar_d;
                pend_valid_d = 1'b1;
              end else begin
                result_d = {sar_d, 6'h00};
              end
              irq_d   = 1'b1;
              state_d = sadc_pkg::SADC_SAMPLE;
              trial_d = '0;
            end else begin
              trial_d = trial_q >> 1;
              sar_d   = sar_d | (trial_q >> 1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q      <= sadc_pkg::SADC_IDLE;
      mode_q       <= sadc_pkg::MODE_RESET;
      chan_q       <= sadc_pkg::CHANNEL_RESET;
      sar_q        <= '0;
      trial_q      <= '0;
      result_q     <= sadc_pkg::RESULT_RESET;
      pend_q       <= '0;
      pend_valid_q <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      state_q      <= state_d;
      mode_q       <= mode_d;
      chan_q       <= chan_d;
      sar_q        <= sar_d;
      trial_q      <= trial_d;
      result_q     <= result_d;
      pend_q       <= pend_d;
      pend_valid_q <= pend_valid_d;
      irq_q        <= irq_d;
    end
  end

  // Read mux; result low bits are forced zero
  always_comb begin
    unique case (bus_addr)
      sadc_pkg::RESULT_LO_ADDR: bus_rdata = {result_q[7:sadc_pkg::RESULT_LSB], 6'h00};
      sadc_pkg::RESULT_HI_ADDR: bus_rdata = result_q[15:8];
      sadc_pkg::MODE_ADDR:      bus_rdata = mode_q;
      sadc_pkg::CHANNEL_ADDR:   bus_rdata = chan_q;
      default:                  bus_rdata = 8'h00;
    endcase
  end

  assign tap_select         = sar_q;
  assign channel_select     = chan_q[2:0];
  assign sample_enable      = state_q == sadc_pkg::SADC_SAMPLE;
  assign conversion_end_irq = irq_q;

  // Register, sequencer and result path checks
  result_zero_a: assert property (@(posedge clk) disable iff (reset)
    result_q[5:0] == 6'h00) else $error("result low bits not zero");
  start_msb_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == sadc_pkg::SADC_SAMPLE && tick && !ctrl_write) |=> sar_q == 10'h200)
    else $error("approximation did not start at bit 9");
  hold_phase_a: assert property (@(posedge clk) disable iff (reset)
    state_q == sadc_pkg::SADC_DECIDE |-> !sample_enable)
    else $error("sampling during decision");
  hold_until_end_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == sadc_pkg::SADC_DECIDE && !done && !ctrl_write) |=> !sample_enable)
    else $error("hold released before the last bit");
  irq_pulse_a: assert property (@(posedge clk) disable iff (reset)
    conversion_end_irq |=> !conversion_end_irq) else $error("request longer than a cycle");
  write_wins_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_write |=> !conversion_end_irq) else $error("request after write");
  disabled_idle_a: assert property (@(posedge clk) disable iff (reset)
    (ctrl_write && !mode_d[sadc_pkg::ENABLE_BIT]) |=> state_q == sadc_pkg::SADC_IDLE)
    else $error("disable did not stop");
  back_to_back_a: assert property (@(posedge clk) disable iff (reset)
    (done && !ctrl_write) |=> sample_enable)
    else $error("no new conversion after the end");
  read_first_a: assert property (@(posedge clk) disable iff (reset)
    (done && result_read && !ctrl_write) |=> $stable(result_q))
    else $error("result changed under read");
  pend_land_a: assert property (@(posedge clk) disable iff (reset)
    (pend_valid_q && !result_read && !done) |=> result_q[15:6] == $past(pend_q))
    else $error("held result did not land");
  latch_end_a: assert property (@(posedge clk) disable iff (reset)
    (done && !result_read && !ctrl_write) |=> conversion_end_irq && result_q[15:6] == sar_q)
    else $error("result not latched with request");
  channel_reg_a: assert property (@(posedge clk) disable iff (reset)
    (bus_write && bus_addr == sadc_pkg::CHANNEL_ADDR) |=> chan_q == $past(bus_wdata))
    else $error("channel write lost");
endmodule

// ### verification/sadc_analog_model.sv
// Analog front end model: six inputs, sample-and-hold and tap comparator.
// Assumes legal channel codes and sample_enable high while sampling.
`timescale 1ns/10ps
module sadc_analog_model (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [5:0][9:0] level,
  input  wire logic [2:0]      channel_select,
  input  wire logic            sample_enable,
  input  wire logic [9:0]      tap_select,
  output logic                 comparator_above
);
  logic [9:0] held_q;
  logic [9:0] held_d;
  // Track the input while sampling; a late level change must not leak in
  always_comb begin
    held_d = held_q;
    if (sample_enable) begin
      held_d = level[channel_select];
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      held_q <= 10'h000;
    end else begin
      held_q <= held_d;
    end
  end
  // At or above the tap reads high
  assign comparator_above = (held_q >= tap_select);
endmodule

// ### verification/testbench.sv
// Self-checking bench for the converter control block.
// Assumes the analog model on the far side and byte register access.
`timescale 1ns/10ps
module testbench;
  logic            clk, reset, bus_write, bus_read, comparator_above;
  logic            sample_enable, conversion_end_irq;
  logic [15:0]     bus_addr, r;
  logic [7:0]      bus_wdata, bus_rdata, b;
  logic [9:0]      tap_select;
  logic [2:0]      channel_select, code;
  logic [5:0][9:0] level;
  int              error_cnt, checks, seed, c, n, ch;

  sadc_control dut_u (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .comparator_above(comparator_above), .tap_select(tap_select),
    .channel_select(channel_select), .sample_enable(sample_enable),
    .conversion_end_irq(conversion_end_irq));
  sadc_analog_model fe_u (.clk(clk), .reset(reset), .level(level),
    .channel_select(channel_select), .sample_enable(sample_enable),
    .tap_select(tap_select), .comparator_above(comparator_above));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input int exp, input logic [15:0] got);
    checks++;
    if (got !== exp[15:0]) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp[15:0], got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask
  // Read data is combinational, so sample it once the address has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    #1 d = bus_rdata;
    @(posedge clk);
    bus_read <= 1'b0;
  endtask
  // One access: read stays high over both bytes, so no new result lands between them
  task automatic rd_result(output logic [15:0] v);
    @(posedge clk);
    bus_addr <= 16'hff14;
    bus_read <= 1'b1;
    #1 v[7:0] = bus_rdata;
    @(posedge clk);
    bus_addr <= 16'hff15;
    #1 v[15:8] = bus_rdata;
    @(posedge clk);
    bus_read <= 1'b0;
  endtask
  // Counts cycles until the end pulse, giving up at the limit
  task automatic wait_irq(input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (conversion_end_irq !== 1'b1 && cyc < lim);
  endtask
  // Reference approximation: trial each bit, keep it when input not below
  function automatic int sar(input int v);
    int res = 0;
    for (int k = 9; k >= 0; k--) if (v >= (res | (1 << k))) res = res | (1 << k);
    return res;
  endfunction
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the planned run
  initial begin
    #(20 * 20000);
    error_cnt++;
    conclude();
  end

  initial begin
    int cyc_tab[4] = '{144, 120, 96, 72};
    logic [2:0] code_tab[4] = '{sadc_pkg::TIME_CODE_144, sadc_pkg::TIME_CODE_120,
                               sadc_pkg::TIME_CODE_96, sadc_pkg::TIME_CODE_72};
    logic [15:0] addr_tab[5] = '{16'hff14, 16'hff15, 16'hff80, 16'hff84, 16'hff00};
    seed = 25934;
    {reset, bus_write, bus_read, bus_addr, bus_wdata} = {1'b1, 1'b0, 1'b0, 16'h0, 8'h0};
    for (int k = 0; k < 6; k++) level[k] = 10'($random(seed));
    level[4] = 10'h000;
    level[5] = 10'h3ff;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // Every register, and an unmapped byte, reads zero after reset
    foreach (addr_tab[i]) begin
      rd(addr_tab[i], b);
      chk("reset value", 0, {8'h00, b});
    end
    // Each time code: back-to-back period and a checked second result
    foreach (code_tab[i]) begin
      ch = $unsigned($random(seed)) % 6;
      code = code_tab[i];
      n = cyc_tab[i];
      wr(16'hff84, 8'(ch));
      wr(16'hff80, {2'b10, code, 3'b000});
      wait_irq(n + 10, c);
      chk("first end", 1, {15'h0, conversion_end_irq});
      wait_irq(n + 10, c);
      chk("period", n, 16'(c));
      rd_result(r);
      chk("result", sar(level[ch]) << 6, r);
      rd(16'hff80, b);
      chk("mode", {2'b10, code, 3'b000}, {8'h00, b});
      chk("channel pins", ch, {13'h0, channel_select});
    end
    // Channel write mid-conversion restarts on the new input
    wait_irq(n + 10, c);
    repeat (n / 2) @(posedge clk);
    wr(16'hff84, 8'h05);
    wait_irq(n + 10, c);
    chk("restart gap", n, 16'(c));
    rd_result(r);
    chk("restart result", sar(level[5]) << 6, r);
    // A result read held over the end keeps the old result until it is released
    wr(16'hff84, 8'h04);
    @(posedge clk);
    bus_addr <= 16'hff15;
    bus_read <= 1'b1;
    wait_irq(n + 10, c);
    chk("held read", sar(level[5]) >> 2, {8'h00, bus_rdata});
    @(posedge clk);
    bus_read <= 1'b0;
    rd_result(r);
    chk("late result", sar(level[4]) << 6, r);
    // Clearing enable stops conversion
    wr(16'hff80, 8'h00);
    wait_irq(2 * n, c);
    chk("idle irq", 2 * n, 16'(c));
    conclude();
  end
endmodule
